//--- obw_defs.svh
// Constants for the object block write command handler
`ifndef OBW_DEFS_SVH
`define OBW_DEFS_SVH
`define OBW_CMD_WRITE      16'h4020
`define OBW_SUB_BLK_WRITE  16'h0006
`define OBW_RSV_BYTE       8'h00
`define OBW_END_OK         16'h0000
`define OBW_ERR_SUBCMD     16'hC059
`define OBW_ERR_MSG        16'hC05C
`define OBW_ERR_LEN        16'hC061
`define OBW_ERR_NO_INDEX   16'hCCCA
`define OBW_ERR_CNT        16'hCCD0
`define OBW_ERR_CNT_BIG    16'hCCD1
`define OBW_ERR_CNT_SMALL  16'hCCD2
`define OBW_ERR_NO_SUB     16'hCCD3
`define OBW_ERR_WO_READ    16'hCCC8
`define OBW_ERR_RO_WRITE   16'hCCC9
`define OBW_ERR_MAP_LOCK   16'hCCC7
`define OBW_ERR_MAP_OBJ    16'hCCCB
`define OBW_ERR_MAP_SIZE   16'hCCCC
`define OBW_ERR_RANGE      16'hCCD4
`define OBW_ERR_RANGE_HI   16'hCCD5
`define OBW_ERR_RANGE_LO   16'hCCD6
`define OBW_ERR_PROTECT    16'hCCDA
`define OBW_HDR_BYTES      4'hA
`define OBW_MAP_SUB_MAX    8'h20
`define OBW_MAP_MAX_BYTES  8'h40
`endif

//--- obw_pkg.sv
// Types for the object block write command handler
package obw_pkg;
  typedef enum logic [2:0] {
    OBW_IDLE,
    OBW_HDR,
    OBW_DATA,
    OBW_CHECK,
    OBW_WRITE,
    OBW_RESP
  } obw_state_e;

  // Verdict from the object dictionary for the current request
  typedef struct packed {
    logic        index_ok;
    logic        sub_ok;
    logic        cnt_big;
    logic        cnt_small;
    logic        cnt_diff;
    logic        write_only_read;
    logic        read_only;
    logic        al_write_locked;
    logic        is_map_obj;
    logic        map_locked;
    logic        map_obj_bad;
    logic [7:0]  map_total_bytes;
    logic        range_hi;
    logic        range_lo;
    logic        range_bad;
    logic        protected_obj;
  } obw_od_s;

  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  sub_index;
    logic [15:0] count;
  } obw_addr_s;

  typedef struct packed {
    obw_state_e  state;
    logic [3:0]  hdr_cnt;
    logic [15:0] cmd;
    logic [15:0] sub_cmd;
    logic [7:0]  rsv;
    obw_addr_s   addr;
    logic [15:0] data_cnt;
    logic [15:0] end_code;
    logic        resp_valid;
    logic        wr_en;
    logic [15:0] wr_pos;
  } obw_state_s;
endpackage

//--- obw_checker_core.sv
// Picks the end code for a parsed request
`timescale 1ns/1ps
`default_nettype none
`include "obw_defs.svh"
module obw_checker_core
  import obw_pkg::*;
(
  input  wire logic [15:0] cmd_in,
  input  wire logic [15:0] sub_cmd_in,
  input  wire logic [7:0]  rsv_in,
  input  wire logic        msg_bad_in,
  input  wire logic        len_bad_in,
  input  wire logic [7:0]  sub_index_in,
  input  wire logic        sub0_nonzero_in,
  input  wire obw_od_s     od_in,
  output logic      [15:0] end_code_out
);
  always_comb begin
    if (cmd_in != `OBW_CMD_WRITE || sub_cmd_in != `OBW_SUB_BLK_WRITE) begin
      end_code_out = `OBW_ERR_SUBCMD;
    end else if (msg_bad_in || rsv_in != `OBW_RSV_BYTE) begin
      end_code_out = `OBW_ERR_MSG;
    end else if (len_bad_in) begin
      end_code_out = `OBW_ERR_LEN;
    end else if (!od_in.index_ok) begin
      end_code_out = `OBW_ERR_NO_INDEX;
    end else if (!od_in.sub_ok) begin
      end_code_out = `OBW_ERR_NO_SUB;
    end else if (od_in.cnt_big) begin
      end_code_out = `OBW_ERR_CNT_BIG;
    end else if (od_in.cnt_small) begin
      end_code_out = `OBW_ERR_CNT_SMALL;
    end else if (od_in.cnt_diff) begin
      end_code_out = `OBW_ERR_CNT;
    end else if (od_in.write_only_read) begin
      end_code_out = `OBW_ERR_WO_READ;
    end else if (od_in.read_only || od_in.al_write_locked) begin
      end_code_out = `OBW_ERR_RO_WRITE;
    end else if (od_in.is_map_obj && od_in.map_locked &&
                 ((sub_index_in == 8'h00 && sub0_nonzero_in) ||
                  (sub_index_in != 8'h00 && sub_index_in <= `OBW_MAP_SUB_MAX))) begin
      end_code_out = `OBW_ERR_MAP_LOCK;
    end else if (od_in.is_map_obj && od_in.map_obj_bad) begin
      end_code_out = `OBW_ERR_MAP_OBJ;
    end else if (od_in.is_map_obj && od_in.map_total_bytes > `OBW_MAP_MAX_BYTES) begin
      end_code_out = `OBW_ERR_MAP_SIZE;
    end else if (od_in.range_hi) begin
      end_code_out = `OBW_ERR_RANGE_HI;
    end else if (od_in.range_lo) begin
      end_code_out = `OBW_ERR_RANGE_LO;
    end else if (od_in.range_bad) begin
      end_code_out = `OBW_ERR_RANGE;
    end else if (od_in.protected_obj) begin
      end_code_out = `OBW_ERR_PROTECT;
    end else begin
      end_code_out = `OBW_END_OK;
    end
  end
endmodule
`default_nettype wire

//--- obw_handler.sv
// Object block write command handler: parses request, checks, writes, answers
`timescale 1ns/1ps
`default_nettype none
`include "obw_defs.svh"
module obw_handler
  import obw_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  // Request byte stream, starting at the command field
  input  wire logic        req_valid_in,
  input  wire logic [7:0]  req_byte_in,
  input  wire logic        req_last_in,
  output logic             req_ready_out,
  // Object dictionary lookup
  output obw_addr_s        od_addr_out,
  output logic             od_sub0_nonzero_out,
  input  wire obw_od_s     od_in,
  input  wire logic        od_valid_in,
  // Object write port, one byte per cycle from the buffer
  output logic             wr_en_out,
  output logic [15:0]      wr_pos_out,
  output logic [7:0]       wr_byte_out,
  // Response header
  output logic             resp_valid_out,
  input  wire logic        resp_ready_in,
  output logic [15:0]      resp_end_code_out,
  output obw_addr_s        resp_addr_out,
  output logic [7:0]       resp_rsv_out
);
  localparam int BUF_DEPTH = 256;

  obw_state_s  st_r;
  obw_state_s  st_nxt;
  logic [7:0]  buf_mem [BUF_DEPTH];
  logic [7:0]  wr_byte_r;
  logic        msg_bad_r;
  logic        msg_bad_nxt;
  logic        sub0_nz_r;
  logic        sub0_nz_nxt;
  logic [15:0] chk_code;
  logic        len_bad;
  logic        hdr_last;
  logic        buf_full;
  logic        buf_we;
  logic        wr_done;

  ////////////////////////////////////////////////////////////////////////////
  // End-code selection
  obw_checker_core u_chk (
    .cmd_in          (st_r.cmd),
    .sub_cmd_in      (st_r.sub_cmd),
    .rsv_in          (st_r.rsv),
    .msg_bad_in      (msg_bad_r),
    .len_bad_in      (len_bad),
    .sub_index_in    (st_r.addr.sub_index),
    .sub0_nonzero_in (sub0_nz_r),
    .od_in           (od_in),
    .end_code_out    (chk_code)
  );

  assign len_bad = st_r.data_cnt != st_r.addr.count;

  // Stream positions and buffer bounds
  assign hdr_last = st_r.hdr_cnt == (`OBW_HDR_BYTES - 4'h1);
  assign buf_full = st_r.data_cnt >= 16'(BUF_DEPTH);
  assign buf_we   = clk_en_in && st_r.state == OBW_DATA && req_valid_in && !buf_full;
  assign wr_done  = st_r.wr_pos == st_r.data_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Request parser and write sequencer
  always_comb begin
    st_nxt      = st_r;
    msg_bad_nxt = msg_bad_r;
    sub0_nz_nxt = sub0_nz_r;
    st_nxt.wr_en = 1'b0;
    unique case (st_r.state)
      // First command byte; stale header fields cleared
      OBW_IDLE: begin
        if (req_valid_in) begin
          st_nxt.cmd      = {8'h00, req_byte_in};
          st_nxt.sub_cmd  = 16'h0000;
          st_nxt.addr     = '0;
          st_nxt.rsv      = 8'h00;
          st_nxt.hdr_cnt  = 4'h1;
          st_nxt.data_cnt = 16'h0000;
          msg_bad_nxt     = req_last_in;
          sub0_nz_nxt     = 1'b0;
          st_nxt.state    = req_last_in ? OBW_CHECK : OBW_HDR;
        end
      end
      // Header bytes one to nine
      OBW_HDR: begin
        if (req_valid_in) begin
          unique case (st_r.hdr_cnt)
            4'h1: st_nxt.cmd[15:8]            = req_byte_in;
            4'h2: st_nxt.sub_cmd[7:0]         = req_byte_in;
            4'h3: st_nxt.sub_cmd[15:8]        = req_byte_in;
            4'h4: st_nxt.addr.index[7:0]      = req_byte_in;
            4'h5: st_nxt.addr.index[15:8]     = req_byte_in;
            4'h6: st_nxt.addr.sub_index       = req_byte_in;
            4'h7: st_nxt.rsv                  = req_byte_in;
            4'h8: st_nxt.addr.count[7:0]      = req_byte_in;
            4'h9: st_nxt.addr.count[15:8]     = req_byte_in;
            default: msg_bad_nxt = 1'b1;
          endcase
          st_nxt.hdr_cnt = st_r.hdr_cnt + 4'h1;
          if (req_last_in) begin
            msg_bad_nxt  = !hdr_last;
            st_nxt.state = OBW_CHECK;
          end else if (hdr_last) begin
            st_nxt.state = OBW_DATA;
          end
        end
      end
      // Write data into the buffer
      OBW_DATA: begin
        if (req_valid_in) begin
          if (st_r.data_cnt == 16'h0000) begin
            sub0_nz_nxt = req_byte_in != 8'h00;
          end else if (req_byte_in != 8'h00) begin
            sub0_nz_nxt = 1'b1;
          end
          if (buf_full) begin
            msg_bad_nxt = 1'b1;
          end
          st_nxt.data_cnt = st_r.data_cnt + 16'h0001;
          if (req_last_in) begin
            st_nxt.state = OBW_CHECK;
          end
        end
      end
      // Wait for the dictionary verdict
      OBW_CHECK: begin
        if (od_valid_in) begin
          st_nxt.end_code = chk_code;
          st_nxt.wr_pos   = 16'h0000;
          if (chk_code == `OBW_END_OK && st_r.data_cnt != 16'h0000) begin
            st_nxt.state = OBW_WRITE;
          end else begin
            st_nxt.state      = OBW_RESP;
            st_nxt.resp_valid = 1'b1;
          end
        end
      end
      // Replay the buffer; answer only after the last pulse
      OBW_WRITE: begin
        if (wr_done) begin
          st_nxt.state      = OBW_RESP;
          st_nxt.resp_valid = 1'b1;
        end else begin
          st_nxt.wr_en  = 1'b1;
          st_nxt.wr_pos = st_r.wr_pos + 16'h0001;
        end
      end
      // Hold the answer until taken
      OBW_RESP: begin
        if (resp_ready_in) begin
          st_nxt.resp_valid = 1'b0;
          st_nxt.state      = OBW_IDLE;
        end
      end
      default: st_nxt.state = OBW_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; clock enable freezes everything
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      st_r      <= '0;
      msg_bad_r <= 1'b0;
      sub0_nz_r <= 1'b0;
      wr_byte_r <= 8'h00;
    end else if (clk_en_in) begin
      st_r      <= st_nxt;
      msg_bad_r <= msg_bad_nxt;
      sub0_nz_r <= sub0_nz_nxt;
      wr_byte_r <= buf_mem[st_r.wr_pos[7:0]];
    end
  end

  // Write data buffer; held until the checks pass
  always_ff @(posedge clk_in) begin
    if (buf_we) begin
      buf_mem[st_r.data_cnt[7:0]] <= req_byte_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign req_ready_out       = st_r.state == OBW_IDLE ||
                               st_r.state == OBW_HDR ||
                               st_r.state == OBW_DATA;
  assign od_addr_out         = st_r.addr;
  assign od_sub0_nonzero_out = sub0_nz_r;
  assign wr_en_out           = st_r.wr_en;
  assign wr_pos_out          = st_r.wr_pos - 16'h0001;
  assign wr_byte_out         = wr_byte_r;
  assign resp_valid_out      = st_r.resp_valid;
  assign resp_end_code_out   = st_r.end_code;
  assign resp_addr_out       = st_r.addr;
  assign resp_rsv_out        = `OBW_RSV_BYTE;
endmodule
`default_nettype wire

//--- obw_props.sv
// Port checker for the object block write handler
`timescale 1ns/1ps
`default_nettype none
module obw_props
  import obw_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        clk_en_in,
  input wire logic        req_ready_out,
  input wire obw_addr_s   od_addr_out,
  input wire logic        wr_en_out,
  input wire logic [15:0] wr_pos_out,
  input wire logic        resp_valid_out,
  input wire logic        resp_ready_in,
  input wire logic [15:0] resp_end_code_out,
  input wire obw_addr_s   resp_addr_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_wr_ok;
    wr_en_out |-> resp_end_code_out == 16'h0000 && !resp_valid_out;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write on error");
  property p_hold;
    resp_valid_out && !(resp_ready_in && clk_en_in) |=> resp_valid_out && $stable(resp_end_code_out);
  endproperty
  a_hold: assert property (p_hold) else $error("response dropped");
  property p_busy;
    resp_valid_out |-> !req_ready_out;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during response");
  property p_echo;
    resp_valid_out && resp_end_code_out == 16'h0000 |-> resp_addr_out == od_addr_out;
  endproperty
  a_echo: assert property (p_echo) else $error("echo differs");
  property p_pos0;
    $rose(wr_en_out) |-> wr_pos_out == 16'h0000;
  endproperty
  a_pos0: assert property (p_pos0) else $error("first offset");
  property p_step;
    wr_en_out && clk_en_in ##1 wr_en_out |-> wr_pos_out == $past(wr_pos_out) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("offset step");
  property p_done;
    wr_en_out && clk_en_in && wr_pos_out == od_addr_out.count - 16'h0001 |=> resp_valid_out;
  endproperty
  a_done: assert property (p_done) else $error("no response after writes");
  property p_accept;
    resp_valid_out && resp_ready_in && clk_en_in |=> !resp_valid_out && req_ready_out;
  endproperty
  a_accept: assert property (p_accept) else $error("second response");
endmodule
bind obw_handler obw_props u_props (.clk_in, .rst_n_in, .clk_en_in, .req_ready_out, .od_addr_out, .wr_en_out,
  .wr_pos_out, .resp_valid_out, .resp_ready_in, .resp_end_code_out, .resp_addr_out);
`default_nettype wire

//--- obw_master_model.sv
// Master side model: sends request bytes, accepts responses
`timescale 1ns/1ps
`default_nettype none
module obw_master_model (
  input  wire logic  clk_in,
  input  wire logic  clk_en_in,
  input  wire logic  req_ready_in,
  input  wire logic  resp_valid_in,
  output logic       req_valid_out,
  output logic [7:0] req_byte_out,
  output logic       req_last_out,
  output logic       resp_ready_out
);
  initial begin
    req_valid_out = 1'b0;
    req_byte_out = 8'h00;
    req_last_out = 1'b0;
    resp_ready_out = 1'b0;
  end
  // Bytes in wire order, each held until taken
  task automatic send(input logic [7:0] b[$]);
    logic taken;
    for (int i = 0; i < b.size(); i++) begin
      req_valid_out = 1'b1;
      req_byte_out = b[i];
      req_last_out = (i == b.size() - 1);
      // Ready judged before the edge that may drop it
      do begin
        @(negedge clk_in);
        taken = req_ready_in && clk_en_in;
        @(posedge clk_in);
      end while (!taken);
      #1;
    end
    req_valid_out = 1'b0;
    req_last_out = 1'b0;
    req_byte_out = ~req_byte_out;
  endtask
  task automatic accept(input int stall);
    logic taken;
    repeat (stall) @(posedge clk_in);
    #1 resp_ready_out = 1'b1;
    do begin
      @(negedge clk_in);
      taken = resp_valid_in && clk_en_in;
      @(posedge clk_in);
    end while (!taken);
    #1 resp_ready_out = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- obw_tb.sv
// Self-checking bench for the object block write handler
`timescale 1ns/1ps
`default_nettype none
module tb;
  import obw_pkg::*;
  logic        clk_in = 0, rst_n_in = 0, clk_en_in = 1, od_valid_in = 1;
  logic        req_valid_in, req_last_in, req_ready_out, od_sub0_nonzero_out, wr_en_out, resp_valid_out, resp_ready_in;
  logic [7:0]  req_byte_in, wr_byte_out, resp_rsv_out;
  logic [15:0] wr_pos_out, resp_end_code_out;
  obw_addr_s   od_addr_out, resp_addr_out, exp_a;
  obw_od_s     od_in = '0;
  int          miscompares = 0, comparisons = 0, wr_n;
  logic [7:0]  exp_q[$], req_q[$];
  initial forever #4 clk_in = ~clk_in;
  obw_handler u_dut (.clk_in, .rst_n_in, .clk_en_in, .req_valid_in, .req_byte_in, .req_last_in, .req_ready_out,
    .od_addr_out, .od_sub0_nonzero_out, .od_in, .od_valid_in, .wr_en_out, .wr_pos_out, .wr_byte_out,
    .resp_valid_out, .resp_ready_in, .resp_end_code_out, .resp_addr_out, .resp_rsv_out);
  obw_master_model u_mst (.clk_in, .clk_en_in, .req_ready_in(req_ready_out), .resp_valid_in(resp_valid_out),
    .req_valid_out(req_valid_in), .req_byte_out(req_byte_in), .req_last_out(req_last_in),
    .resp_ready_out(resp_ready_in));
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] s);
    comparisons++;
    if (s !== e) begin
      $display("ERROR %s expected %0h seen %0h", n, e, s);
      miscompares++;
    end
  endtask
  always @(negedge clk_in) if (wr_en_out === 1'b1 && clk_en_in === 1'b1) begin
    chk("wr_pos", wr_n, wr_pos_out);
    chk("wr_byte", exp_q[wr_n], wr_byte_out);
    wr_n++;
  end
  function automatic void mk(input logic [15:0] c, sc, input logic [7:0] si, rv, input logic [15:0] n,
                             input int nd, input logic [7:0] v);
    req_q = '{c[7:0], c[15:8], sc[7:0], sc[15:8], 8'h45, 8'h23, si, rv, n[7:0], n[15:8]};
    exp_a = '{16'h2345, si, n};
    exp_q = {};
    for (int i = 0; i < nd; i++) exp_q.push_back(v & (8'hF0 | i[7:0]));
    req_q = {req_q, exp_q};
  endfunction
  task automatic run(input string nm, input logic [22:0] od, input logic [15:0] code, input int stall);
    int t = 0;
    logic nz = 1'b0;
    od_in = od;
    wr_n = 0;
    u_mst.send(req_q);
    while (resp_valid_out !== 1'b1 && t < 600) begin
      @(posedge clk_in);
      #1 t++;
    end
    foreach (exp_q[i]) nz = nz | (exp_q[i] != 8'h00);
    chk("resp_valid", 1'b1, resp_valid_out);
    chk("sub0_nz", nz, od_sub0_nonzero_out);
    chk(nm, code, resp_end_code_out);
    chk("writes", code == 16'h0000 ? exp_q.size() : 0, wr_n);
    chk("rsv", 8'h00, resp_rsv_out);
    if (code == 16'h0000) chk("echo", exp_a, resp_addr_out);
    u_mst.accept(stall);
  endtask
  ////////////////////////////////////////
  task automatic t_ok();
    mk(16'h4020, 16'h0006, 8'h01, 8'h00, 16'h0003, 3, 8'hFF);
    od_valid_in = 1'b0;
    fork begin
      repeat (3) @(posedge clk_in);
      #1 clk_en_in = 1'b0;
      repeat (3) @(posedge clk_in);
      #1 clk_en_in = 1'b1;
      repeat (20) @(posedge clk_in);
      #1 chk("early", 2'b00, {resp_valid_out, wr_en_out});
      od_valid_in = 1'b1;
    end join_none
    run("ok", 23'h600000, 16'h0000, 3);
    $display("test ok done");
  endtask
  task automatic t_od();
    logic [22:0] m[16] = '{23'h400000, 23'h200000, 23'h100000, 23'h080000, 23'h040000, 23'h020000, 23'h010000,
      23'h008000, 23'h006000, 23'h005000, 23'h004410, 23'h000008, 23'h000004, 23'h000002, 23'h000001, 23'h004400};
    logic [15:0] c[16] = '{16'hCCCA, 16'hCCD3, 16'hCCD1, 16'hCCD2, 16'hCCD0, 16'hCCC8, 16'hCCC9, 16'hCCC9,
      16'hCCC7, 16'hCCCB, 16'hCCCC, 16'hCCD5, 16'hCCD6, 16'hCCD4, 16'hCCDA, 16'h0000};
    for (int i = 0; i < 16; i++) begin
      mk(16'h4020, 16'h0006, 8'h01, 8'h00, 16'h0002, 2, 8'hFF);
      run("od_code", 23'h600000 ^ m[i], c[i], i % 3);
    end
    $display("test od done");
  endtask
  task automatic t_msg();
    mk(16'h4021, 16'h0006, 8'h01, 8'h00, 16'h0002, 2, 8'hFF);
    run("cmd", 23'h600000, 16'hC059, 0);
    mk(16'h4020, 16'h0005, 8'h01, 8'h00, 16'h0002, 2, 8'hFF);
    run("subcmd", 23'h600000, 16'hC059, 1);
    mk(16'h4020, 16'h0006, 8'h01, 8'h01, 16'h0002, 2, 8'hFF);
    run("rsv_bad", 23'h600000, 16'hC05C, 0);
    mk(16'h4020, 16'h0006, 8'h01, 8'h00, 16'h0003, 2, 8'hFF);
    run("len", 23'h600000, 16'hC061, 0);
    mk(16'h4020, 16'h0006, 8'h01, 8'h00, 16'h0000, 0, 8'h00);
    req_q = req_q[0:4];
    run("short", 23'h600000, 16'hC05C, 0);
    mk(16'h4020, 16'h0006, 8'h00, 8'h00, 16'h0002, 2, 8'hFF);
    run("map0", 23'h606000, 16'hCCC7, 0);
    mk(16'h4020, 16'h0006, 8'h00, 8'h00, 16'h0002, 2, 8'h00);
    run("map0_zero", 23'h606000, 16'h0000, 2);
    $display("test msg done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    chk("reset", 3'b100, {req_ready_out, resp_valid_out, wr_en_out});
    t_ok();
    t_od();
    t_msg();
    end_of_test();
  end
  initial begin
    #100000;
    miscompares++;
    end_of_test();
  end
endmodule
`default_nettype wire
